// [common/ucl_regs.svh]
`ifndef UCL_REGS_SVH
`define UCL_REGS_SVH
// row address in the nonvolatile space
`define UCL_ROW_BASE 24'h804000
`define UCL_ROW_WORD1 24'h804004
// apb register byte offsets
`define UCL_REG_ROW_LO 12'h000
`define UCL_REG_ROW_HI 12'h004
`define UCL_REG_CTRL 12'h008
`define UCL_REG_STATUS 12'h00C
// field positions in the 64-bit row
`define UCL_BOOT_PROTECT_SIZE_LSB 0
`define UCL_EEPROM_LSB 4
`define UCL_BODLVL_LSB 8
`define UCL_BODEN_BIT 14
`define UCL_BODACT_LSB 15
`define UCL_WDTEN_BIT 25
`define UCL_WDTAON_BIT 26
`define UCL_WDTPER_LSB 27
`define UCL_WDTWIN_LSB 31
`define UCL_EWOFF_LSB 35
`define UCL_WDTWEN_BIT 39
`define UCL_BODHYS_BIT 40
`define UCL_LOCK_LSB 48
// erased defaults of the fields
`define UCL_BOOT_PROTECT_SIZE_DEF 3'h7
`define UCL_BOOT_PROTECT_SIZE_ALT 3'h3
`define UCL_EEPROM_DEF 3'h7
`define UCL_BODLVL_DEF 6'h07
`define UCL_BODLVL_EXT 6'h22
`define UCL_BODEN_DEF 1'h1
`define UCL_BODACT_DEF 2'h1
`define UCL_WDTEN_DEF 1'h0
`define UCL_WDTAON_DEF 1'h0
`define UCL_WDTPER_DEF 4'hB
`define UCL_WDTWIN_DEF 4'hB
`define UCL_EWOFF_DEF 4'hB
`define UCL_WDTWEN_DEF 1'h0
`define UCL_BODHYS_DEF 1'h1
`define UCL_LOCK_DEF 16'hFFFF
`endif

// [common/ucl_pkg.sv]
package ucl_pkg;
	typedef enum logic [3:0] {
		UCL_RD0 = 4'h1,
		UCL_RD1 = 4'h2,
		UCL_HOLD = 4'h4,
		UCL_DONE = 4'h8
	} ucl_state_t;
	typedef struct packed {
		ucl_state_t st;
		logic [63:0] row;
		logic [23:0] nv_addr;
		logic nv_req;
		logic sys_rst_n;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic reload;
	} ucl_st_t;
endpackage

// [src/ucl_loader.sv]
// Register access over APB was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "ucl_regs.svh"
// How it works
// - fetch first two row words at power-on
// - row read at byte address 0x804000
// - new row contents apply only after reset or a reload request
// - bits 2:0 give boot-protection size
// - bits 6:4 give emulated-EEPROM size
// - bits 13:8 give brown-out level
// - bit 14 gives brown-out enable
// - bits 16:15 give brown-out action
// - bits 25,26 give watchdog enable, always-on
// - bits 30:27 give watchdog period
// - bits 34:31 give window time-out, spanning words
// - bits 38:35 give early-warning offset
// - bit 39 gives window-mode enable
// - bit 40 gives brown-out hysteresis
// - bits 63:48 give sixteen region locks
module ucl_loader #(
	parameter bit EXT_TEMP = 1'b0,
	parameter bit ALT_PKG = 1'b0
) (
	input wire logic clk_sys_in,
	input wire logic rstn_in,
	input wire logic ce_in,
	output logic nv_req_out,
	output logic [23:0] nv_addr_out,
	input wire logic nv_ack_in,
	input wire logic [31:0] nv_rdata_in,
	output logic sys_rstn_out,
	output logic [2:0] boot_protect_size_out,
	output logic [2:0] eeprom_size_out,
	output logic [5:0] bod_level_out,
	output logic bod_enable_out,
	output logic [1:0] bod_action_out,
	output logic bod_hyst_out,
	output logic wdt_enable_out,
	output logic wdt_always_on_out,
	output logic [3:0] wdt_period_out,
	output logic [3:0] wdt_window_out,
	output logic [3:0] early_warning_offset_out,
	output logic wdt_window_en_out,
	output logic [15:0] region_lock_out,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out
);
	ucl_pkg::ucl_st_t q, d;

	function automatic logic [63:0] ucl_defaults(input logic ext, input logic alt);
		logic [63:0] r;
		r = 64'h0;
		r[`UCL_BOOT_PROTECT_SIZE_LSB +: 3] = alt ? `UCL_BOOT_PROTECT_SIZE_ALT : `UCL_BOOT_PROTECT_SIZE_DEF;
		r[`UCL_EEPROM_LSB +: 3] = `UCL_EEPROM_DEF;
		r[`UCL_BODLVL_LSB +: 6] = ext ? `UCL_BODLVL_EXT : `UCL_BODLVL_DEF;
		r[`UCL_BODEN_BIT] = `UCL_BODEN_DEF;
		r[`UCL_BODACT_LSB +: 2] = `UCL_BODACT_DEF;
		r[`UCL_WDTEN_BIT] = `UCL_WDTEN_DEF;
		r[`UCL_WDTAON_BIT] = `UCL_WDTAON_DEF;
		r[`UCL_WDTPER_LSB +: 4] = `UCL_WDTPER_DEF;
		r[`UCL_WDTWIN_LSB +: 4] = `UCL_WDTWIN_DEF;
		r[`UCL_EWOFF_LSB +: 4] = `UCL_EWOFF_DEF;
		r[`UCL_WDTWEN_BIT] = `UCL_WDTWEN_DEF;
		r[`UCL_BODHYS_BIT] = `UCL_BODHYS_DEF;
		r[`UCL_LOCK_LSB +: 16] = `UCL_LOCK_DEF;
		return r;
	endfunction

	// a word is taken only while our own request still stands
	function automatic logic ucl_nv_take(input logic req, input logic ack);
		return req && ack;
	endfunction

	// merge one fetched word into its half of the row image
	function automatic logic [63:0] ucl_merge_word(input logic [63:0] row,
		input logic [31:0] word, input logic hi);
		logic [63:0] r;
		r = row;
		if (hi) begin
			r[63:32] = word;
		end else begin
			r[31:0] = word;
		end
		return r;
	endfunction

	// decode of the four word offsets; anything else answers with an error
	function automatic logic ucl_reg_known(input logic [11:0] addr);
		logic known;
		known = 1'b0;
		case (addr)
			`UCL_REG_ROW_LO: begin
				known = 1'b1;
			end
			`UCL_REG_ROW_HI: begin
				known = 1'b1;
			end
			`UCL_REG_CTRL: begin
				known = 1'b1;
			end
			`UCL_REG_STATUS: begin
				known = 1'b1;
			end
			default: begin
				known = 1'b0;
			end
		endcase
		return known;
	endfunction

	// control reads as zero since reload is a one-shot request
	function automatic logic [31:0] ucl_rd_word(input logic [63:0] row,
		input logic [11:0] addr, input logic done);
		logic [31:0] w;
		w = 32'h0;
		case (addr)
			`UCL_REG_ROW_LO: begin
				w = row[31:0];
			end
			`UCL_REG_ROW_HI: begin
				w = row[63:32];
			end
			`UCL_REG_STATUS: begin
				w = {31'h0, done};
			end
			default: begin
				w = 32'h0;
			end
		endcase
		return w;
	endfunction

	// only the control word takes writes
	function automatic logic ucl_wr_error(input logic [11:0] addr, input logic wr);
		logic err;
		err = 1'b0;
		if (wr && addr != `UCL_REG_CTRL) begin
			err = 1'b1;
		end
		return err;
	endfunction

	logic apb_acc;
	logic apb_wr;
	assign apb_acc = psel_in && penable_in;
	assign apb_wr = apb_acc && pwrite_in;

	logic loaded;
	logic reload_req;
	assign loaded = q.st == ucl_pkg::UCL_DONE;
	// refused mid-fetch so a half-loaded row never reaches consumers
	assign reload_req = apb_wr && paddr_in == `UCL_REG_CTRL && pwdata_in[0] && loaded;

	always_comb begin
		d = q;
		d.pready = 1'b0;
		d.pslverr = 1'b0;
		case (q.st)
			ucl_pkg::UCL_RD0: begin
				d.nv_req = 1'b1;
				d.nv_addr = `UCL_ROW_BASE;
				if (ucl_nv_take(q.nv_req, nv_ack_in)) begin
					d.row = ucl_merge_word(q.row, nv_rdata_in, 1'b0);
					d.nv_addr = `UCL_ROW_WORD1;
					d.st = ucl_pkg::UCL_RD1;
				end
			end
			ucl_pkg::UCL_RD1: begin
				if (ucl_nv_take(q.nv_req, nv_ack_in)) begin
					d.row = ucl_merge_word(q.row, nv_rdata_in, 1'b1);
					d.nv_req = 1'b0;
					d.st = ucl_pkg::UCL_HOLD;
				end
			end
			ucl_pkg::UCL_HOLD: begin
				// one cycle so consumers see stable fields before release
				d.sys_rst_n = 1'b1;
				d.st = ucl_pkg::UCL_DONE;
			end
			ucl_pkg::UCL_DONE: begin
				// row is frozen until the next reset or a reload request
				if (q.reload) begin
					d.reload = 1'b0;
					d.sys_rst_n = 1'b0;
					d.st = ucl_pkg::UCL_RD0;
				end
			end
			default: begin
				d.st = ucl_pkg::UCL_RD0;
			end
		endcase
		if (apb_acc && !q.pready) begin
			// one wait state: the answer is registered
			d.pready = 1'b1;
			d.prdata = ucl_rd_word(q.row, paddr_in, loaded);
			if (!ucl_reg_known(paddr_in)) begin
				d.pslverr = 1'b1;
			end
			if (ucl_wr_error(paddr_in, apb_wr)) begin
				d.pslverr = 1'b1;
			end
			// bit 0 requests a reload, acting as a local reset
			if (reload_req) begin
				d.reload = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			q.st <= ucl_pkg::UCL_RD0;
			q.row <= ucl_defaults(EXT_TEMP, ALT_PKG);
			q.nv_addr <= `UCL_ROW_BASE;
			q.nv_req <= 1'b0;
			q.sys_rst_n <= 1'b0;
			q.pready <= 1'b0;
			q.pslverr <= 1'b0;
			q.prdata <= 32'h0;
			q.reload <= 1'b0;
		end else if (ce_in) begin
			q <= d;
		end
	end

	assign nv_req_out = q.nv_req;
	assign nv_addr_out = q.nv_addr;
	assign sys_rstn_out = q.sys_rst_n;
	assign boot_protect_size_out = q.row[`UCL_BOOT_PROTECT_SIZE_LSB +: 3];
	assign eeprom_size_out = q.row[`UCL_EEPROM_LSB +: 3];
	assign bod_level_out = q.row[`UCL_BODLVL_LSB +: 6];
	assign bod_enable_out = q.row[`UCL_BODEN_BIT];
	assign bod_action_out = q.row[`UCL_BODACT_LSB +: 2];
	assign wdt_enable_out = q.row[`UCL_WDTEN_BIT];
	assign wdt_always_on_out = q.row[`UCL_WDTAON_BIT];
	assign wdt_period_out = q.row[`UCL_WDTPER_LSB +: 4];
	assign wdt_window_out = q.row[`UCL_WDTWIN_LSB +: 4];
	assign early_warning_offset_out = q.row[`UCL_EWOFF_LSB +: 4];
	assign wdt_window_en_out = q.row[`UCL_WDTWEN_BIT];
	assign bod_hyst_out = q.row[`UCL_BODHYS_BIT];
	assign region_lock_out = q.row[`UCL_LOCK_LSB +: 16];
	assign prdata_out = q.prdata;
	assign pready_out = q.pready;
	assign pslverr_out = q.pslverr;
endmodule // ucl_loader
`default_nettype wire

// [tb/ucl_props.sv]
`timescale 1ns/1ps
`default_nettype none
module ucl_props (
	input wire logic clk_sys_in,
	input wire logic rstn_in,
	input wire logic ce_in,
	input wire logic nv_req_out,
	input wire logic [23:0] nv_addr_out,
	input wire logic nv_ack_in,
	input wire logic [31:0] nv_rdata_in,
	input wire logic sys_rstn_out,
	input wire logic [2:0] boot_protect_size_out,
	input wire logic [5:0] bod_level_out,
	input wire logic [3:0] wdt_window_out,
	input wire logic [15:0] region_lock_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rstn_in);
	wire w0 = nv_req_out & nv_ack_in & ce_in & nv_addr_out == 24'h804000;
	wire w1 = nv_req_out & nv_ack_in & ce_in & nv_addr_out == 24'h804004;
	property p_first; $rose(nv_req_out) |-> nv_addr_out == 24'h804000; endproperty
	property p_nx; w0 |=> nv_req_out && nv_addr_out == 24'h804004; endproperty
	property p_bp; w0 |=> boot_protect_size_out == $past(nv_rdata_in[2:0]); endproperty
	property p_lv; w0 |=> bod_level_out == $past(nv_rdata_in[13:8]); endproperty
	property p_win; w1 |=> wdt_window_out[3:1] == $past(nv_rdata_in[2:0]); endproperty
	property p_lock; w1 |=> region_lock_out == $past(nv_rdata_in[31:16]); endproperty
	property p_rel; w1 |=> !nv_req_out ##1 sys_rstn_out; endproperty
	property p_hold; sys_rstn_out && $past(sys_rstn_out) |-> $stable(region_lock_out); endproperty
	a_first: assert property (p_first) else $error("first addr");
	a_nx: assert property (p_nx) else $error("second addr");
	a_bp: assert property (p_bp) else $error("boot size");
	a_lv: assert property (p_lv) else $error("bod level");
	a_win: assert property (p_win) else $error("window split");
	a_lock: assert property (p_lock) else $error("locks");
	a_rel: assert property (p_rel) else $error("release");
	a_hold: assert property (p_hold) else $error("held");
	c_w0: cover property (w0);
	c_w1: cover property (w1);
	c_rel: cover property ($rose(sys_rstn_out));
endmodule // ucl_props
bind ucl_loader ucl_props u_props (.*);
`default_nettype wire

// [tb/ucl_nvm_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ucl_nvm_model (
	input wire logic clk_sys_in,
	input wire logic rstn_in,
	input wire logic nv_req_out,
	input wire logic [23:0] nv_addr_out,
	input wire logic [63:0] row,
	input wire logic [1:0] lat,
	output logic nv_ack_in,
	output logic [31:0] nv_rdata_in
);
	logic [1:0] cnt;
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cnt <= 2'h0;
			nv_ack_in <= 1'h0;
			nv_rdata_in <= 32'h0;
		end else if (nv_req_out && !nv_ack_in && cnt == lat) begin
			cnt <= 2'h0;
			nv_ack_in <= 1'h1;
			nv_rdata_in <= nv_addr_out[2] ? row[63:32] : row[31:0];
		end else begin
			cnt <= cnt + (nv_req_out && !nv_ack_in);
			nv_ack_in <= 1'h0;
			// data invalid off the strobe
			nv_rdata_in <= ~nv_rdata_in;
		end
	end
endmodule // ucl_nvm_model
`default_nettype wire

// [tb/ucl_loader_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module ucl_loader_tb;
	localparam logic [63:0] MK = 64'hFFFF01FFFE01FF77;
	localparam logic [63:0] RA = 64'h1234A5C39E6BF0D5;
	logic clk_sys_in = 1'h0, rstn_in, ce_in = 1'h1, psel_in = 1'h0, penable_in = 1'h0;
	logic pwrite_in = 1'h0, e, nv_req_out, nv_ack_in, sys_rstn_out, pready_out, pslverr_out;
	logic bod_enable_out, bod_hyst_out, wdt_enable_out, wdt_always_on_out, wdt_window_en_out;
	logic [11:0] paddr_in = 12'h000;
	logic [31:0] pwdata_in = 32'h1, prdata_out, nv_rdata_in, d;
	logic [23:0] nv_addr_out;
	logic [63:0] row = RA;
	logic [1:0] lat = 2'h0, bod_action_out;
	logic [2:0] boot_protect_size_out, eeprom_size_out;
	logic [5:0] bod_level_out;
	logic [3:0] wdt_period_out, wdt_window_out, early_warning_offset_out;
	logic [15:0] region_lock_out;
	int error_cnt = 0, checks = 0, cyc = 0;
	ucl_loader dut (.*);
	ucl_nvm_model nvm (.*);
	// outputs packed back into row positions, reserved bits as zero
	wire [63:0] f = {region_lock_out, 7'h00, bod_hyst_out, wdt_window_en_out,
		early_warning_offset_out, wdt_window_out, wdt_period_out, wdt_always_on_out,
		wdt_enable_out, 8'h00, bod_action_out, bod_enable_out, bod_level_out, 1'h0,
		eeprom_size_out, 1'h0, boot_protect_size_out};
	task automatic chk(string n, logic [63:0] g, logic [63:0] x);
		checks++;
		if (g !== x) begin
			error_cnt++;
			$display("[FAIL] %s exp %h got %h", n, x, g);
		end
	endtask
	task automatic apb(logic w, logic [11:0] a);
		@(posedge clk_sys_in);
		psel_in <= 1'h1;
		pwrite_in <= w;
		paddr_in <= a;
		@(posedge clk_sys_in);
		penable_in <= 1'h1;
		do @(posedge clk_sys_in); while (pready_out !== 1'h1);
		d = prdata_out;
		e = pslverr_out;
		psel_in <= 1'h0;
		penable_in <= 1'h0;
	endtask
	task automatic end_sim;
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial forever #2.5 clk_sys_in = ~clk_sys_in;
	always @(posedge clk_sys_in) if (++cyc > 4000) begin
		error_cnt++;
		end_sim();
	end
	initial begin
		// a real falling edge so the asynchronous reset is seen at time zero
		rstn_in <= 1'h0;
		repeat (10) @(posedge clk_sys_in);
		chk("dflt", f, 64'hFFFF015DD800C777);
		rstn_in <= 1'h1;
		wait (sys_rstn_out === 1'h1);
		chk("rowa", f, RA & MK);
		apb(1'h0, 12'h000);
		chk("lo", d, RA[31:0]);
		apb(1'h0, 12'h004);
		chk("hi", d, RA[63:32]);
		apb(1'h0, 12'h010);
		chk("unmapped", e, 1);
		apb(1'h0, 12'h00C);
		chk("status", d, 32'h1);
		apb(1'h1, 12'h000);
		chk("ro_write", e, 1);
		chk("ro_kept", f, RA & MK);
		row <= (~RA & MK) | (RA & ~MK);
		lat <= 2'h3;
		repeat (20) @(posedge clk_sys_in);
		chk("kept", f, RA & MK);
		apb(1'h1, 12'h008);
		ce_in <= 1'h0;
		repeat (8) @(posedge clk_sys_in);
		chk("frozen", {sys_rstn_out, nv_req_out}, 2'h0);
		ce_in <= 1'h1;
		wait (sys_rstn_out === 1'h0);
		wait (sys_rstn_out === 1'h1);
		chk("rowb", f, ~RA & MK);
		end_sim();
	end
endmodule // ucl_loader_tb
`default_nettype wire
